// file: core/qmc_consts.svh
// Register indices, field positions, reset values and fixed-point constants
`ifndef QMC_CONSTS_SVH
`define QMC_CONSTS_SVH

// Register indices; byte address is four times the index
`define QMC_IDX_OFFSET_C 6'h0A
`define QMC_IDX_OFFSET_D 6'h0B
`define QMC_IDX_GAIN_A 6'h0C
`define QMC_IDX_MIX_GAIN_B 6'h0D
`define QMC_IDX_SYNC_CTRL 6'h1E
`define QMC_IDX_STATUS 6'h1F

// Field layout
`define QMC_OFFSET_MSB 12
`define QMC_GAIN_MSB 10
`define QMC_CMIX_MSB 15
`define QMC_CMIX_LSB 12
`define QMC_SYNC_EN_BIT 0
`define QMC_SYNC_LOAD_BIT 1
`define QMC_STAT_D_LSB 16
`define QMC_STAT_D_MSB 28

// Reset values
`define QMC_RST_OFFSET 13'h0000
`define QMC_RST_GAIN 11'h400
`define QMC_RST_CMIX 4'h0
`define QMC_RST_SYNC_EN 1'b1

// Datapath constants
`define QMC_DATA_W 16
`define QMC_GAIN_W 11
`define QMC_OFFSET_W 13
`define QMC_GAIN_FRAC 10
`define QMC_ROT45 17'h05A82
`define QMC_ROT45_FRAC 15
`define QMC_MIX_NEG_FS4 3'h6

`endif

// file: core/qmc_pkg.sv
// Types for the register block of the correction and mixer datapath
package qmc_pkg;

    typedef enum logic [2:0] {
        SEL_NONE = 3'b000,
        SEL_OFFSET_C = 3'b001,
        SEL_OFFSET_D = 3'b010,
        SEL_GAIN_A = 3'b011,
        SEL_MIX_GAIN_B = 3'b100,
        SEL_SYNC_CTRL = 3'b101,
        SEL_STATUS = 3'b110
    } reg_sel_t;

    typedef logic [1:0] rot_quarter_t;

endpackage : qmc_pkg

// file: core/gain_offset_lane.sv
// One channel of gain multiply, offset add and saturation
`timescale 1ns/1ps
`default_nettype none
`include "qmc_consts.svh"

module gain_offset_lane #(
    parameter int DW = `QMC_DATA_W,
    parameter int GW = `QMC_GAIN_W,
    parameter int OW = `QMC_OFFSET_W,
    parameter int FRAC = `QMC_GAIN_FRAC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic signed [DW-1:0] sample_in,
    input wire logic [GW-1:0] gain,
    input wire logic signed [OW-1:0] offset,
    output logic signed [DW-1:0] sample_out
);
    localparam int PW = DW + GW + 1;
    localparam logic signed [PW:0] MAXV = (PW+1)'((1 <<< (DW - 1)) - 1);
    localparam logic signed [PW:0] MINV = -MAXV - (PW+1)'(1);

    logic signed [PW-1:0] prod;
    logic signed [PW:0] sum;
    logic signed [DW-1:0] out_reg;
    logic signed [DW-1:0] out_next;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        // Gain is unsigned with one integer bit, so it gets a zero sign bit
        prod = sample_in * $signed({1'b0, gain});
        sum = (PW+1)'(prod >>> FRAC) + (PW+1)'(offset);
        if (sum > MAXV) begin
            out_next = DW'(MAXV);
        end else if (sum < MINV) begin
            out_next = DW'(MINV);
        end else begin
            out_next = DW'(sum);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            out_reg <= '0;
        end else if (ce) begin
            out_reg <= out_next;
        end
    end

    assign sample_out = out_reg;

endmodule : gain_offset_lane
`default_nettype wire

// file: core/coarse_mixer.sv
// Coarse complex mixer: rotation by multiples of Fs/8 on an I/Q pair
`timescale 1ns/1ps
`default_nettype none
`include "qmc_consts.svh"

module coarse_mixer #(
    parameter int DW = `QMC_DATA_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [3:0] mode,
    input wire logic signed [DW-1:0] i_in,
    input wire logic signed [DW-1:0] q_in,
    output logic signed [DW-1:0] i_out,
    output logic signed [DW-1:0] q_out
);
    localparam int RW = DW + 2;
    localparam logic signed [RW-1:0] MAXV = RW'((1 <<< (DW - 1)) - 1);
    localparam logic signed [RW-1:0] MINV = -MAXV - RW'(1);

    logic [2:0] phase_reg;
    logic [2:0] phase_next;
    logic [2:0] step;
    logic signed [DW:0] diff;
    logic signed [DW:0] summ;
    logic signed [2*DW+1:0] pd;
    logic signed [2*DW+1:0] ps;
    logic signed [RW-1:0] ri;
    logic signed [RW-1:0] rq;
    logic signed [RW-1:0] xi;
    logic signed [RW-1:0] xq;
    logic signed [DW-1:0] i_reg;
    logic signed [DW-1:0] q_reg;
    logic signed [DW-1:0] i_next;
    logic signed [DW-1:0] q_next;

    function automatic logic signed [DW-1:0] sat(input logic signed [RW-1:0] v);
        if (v > MAXV) begin
            sat = DW'(MAXV);
        end else if (v < MINV) begin
            sat = DW'(MINV);
        end else begin
            sat = DW'(v);
        end
    endfunction : sat

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        // Selected mixers cascade: their shifts add modulo a full turn
        step = 3'(mode[3]) + {1'b0, mode[2], 1'b0} + {mode[1], 2'b00}
            + (mode[0] ? `QMC_MIX_NEG_FS4 : 3'h0);
        // No net shift holds phase at zero so the pair passes unchanged
        phase_next = (step == 3'h0) ? 3'h0 : phase_reg + step;
        diff = (DW+1)'(i_in) - (DW+1)'(q_in);
        summ = (DW+1)'(i_in) + (DW+1)'(q_in);
        pd = diff * $signed(`QMC_ROT45);
        ps = summ * $signed(`QMC_ROT45);
        if (phase_reg[0]) begin
            ri = RW'(pd >>> `QMC_ROT45_FRAC);
            rq = RW'(ps >>> `QMC_ROT45_FRAC);
        end else begin
            ri = RW'(i_in);
            rq = RW'(q_in);
        end
        unique case (phase_reg[2:1])
            2'b00: begin
                xi = ri;
                xq = rq;
            end
            2'b01: begin
                xi = -rq;
                xq = ri;
            end
            2'b10: begin
                xi = -ri;
                xq = -rq;
            end
            2'b11: begin
                xi = rq;
                xq = -ri;
            end
        endcase
        i_next = sat(xi);
        q_next = sat(xq);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            phase_reg <= 3'h0;
            i_reg <= '0;
            q_reg <= '0;
        end else if (ce) begin
            phase_reg <= phase_next;
            i_reg <= i_next;
            q_reg <= q_next;
        end
    end

    assign i_out = i_reg;
    assign q_out = q_reg;

endmodule : coarse_mixer
`default_nettype wire

// file: core/qmc_cmix_top.sv
// Gain, offset and coarse mixer settings with the four-lane correction datapath
`timescale 1ns/1ps
`default_nettype none
`include "qmc_consts.svh"

module qmc_cmix_top #(
    parameter int DW = `QMC_DATA_W,
    parameter int AW = 8
) (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [AW-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic signed [DW-1:0] SAMPLE_A_IN,
    input wire logic signed [DW-1:0] SAMPLE_B_IN,
    input wire logic signed [DW-1:0] SAMPLE_C_IN,
    input wire logic signed [DW-1:0] SAMPLE_D_IN,
    output logic signed [DW-1:0] SAMPLE_A_OUT,
    output logic signed [DW-1:0] SAMPLE_B_OUT,
    output logic signed [DW-1:0] SAMPLE_C_OUT,
    output logic signed [DW-1:0] SAMPLE_D_OUT
);
    localparam int OW = `QMC_OFFSET_W;
    localparam int GW = `QMC_GAIN_W;

    qmc_pkg::reg_sel_t sel;
    logic access;
    logic wr_en;
    logic rd_cap;
    logic sync_load;

    logic [OW-1:0] offset_word_ch_c_reg;
    logic [OW-1:0] offset_word_ch_c_next;
    logic [OW-1:0] offset_word_ch_d_reg;
    logic [OW-1:0] offset_word_ch_d_next;
    logic [GW-1:0] gain_word_ch_a_reg;
    logic [GW-1:0] gain_word_ch_a_next;
    logic [GW-1:0] gain_word_ch_b_reg;
    logic [GW-1:0] gain_word_ch_b_next;
    logic [3:0] cmix_mode_reg;
    logic [3:0] cmix_mode_next;
    logic sync_en_reg;
    logic sync_en_next;
    logic [OW-1:0] active_c_reg;
    logic [OW-1:0] active_c_next;
    logic [OW-1:0] active_d_reg;
    logic [OW-1:0] active_d_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic [31:0] rd_mux;

    logic signed [DW-1:0] lane_in [4];
    logic [GW-1:0] lane_gain [4];
    logic signed [OW-1:0] lane_off [4];
    logic signed [DW-1:0] lane_out [4];

    ////////////////////////////////////////////////////////////////////////////
    // APB decode: zero wait states, so the access phase ends in its first
    // cycle unless the clock enable is holding the block frozen
    always_comb begin
        unique case (PADDR[AW-1:2])
            (AW-2)'(`QMC_IDX_OFFSET_C): sel = qmc_pkg::SEL_OFFSET_C;
            (AW-2)'(`QMC_IDX_OFFSET_D): sel = qmc_pkg::SEL_OFFSET_D;
            (AW-2)'(`QMC_IDX_GAIN_A): sel = qmc_pkg::SEL_GAIN_A;
            (AW-2)'(`QMC_IDX_MIX_GAIN_B): sel = qmc_pkg::SEL_MIX_GAIN_B;
            (AW-2)'(`QMC_IDX_SYNC_CTRL): sel = qmc_pkg::SEL_SYNC_CTRL;
            (AW-2)'(`QMC_IDX_STATUS): sel = qmc_pkg::SEL_STATUS;
            default: sel = qmc_pkg::SEL_NONE;
        endcase
        if (PADDR[1:0] != 2'h0) begin
            sel = qmc_pkg::SEL_NONE;
        end
    end

    assign PREADY = CE;
    assign access = PSEL && PENABLE && CE;
    assign wr_en = access && PWRITE;
    assign rd_cap = PSEL && CE;
    assign PSLVERR = PSEL && PENABLE && (sel == qmc_pkg::SEL_NONE);
    assign PRDATA = prdata_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Read mux: only implemented field bits are stored, the rest read zero
    always_comb begin
        rd_mux = 32'h0;
        unique case (sel)
            qmc_pkg::SEL_OFFSET_C: rd_mux[`QMC_OFFSET_MSB:0] = offset_word_ch_c_reg;
            qmc_pkg::SEL_OFFSET_D: rd_mux[`QMC_OFFSET_MSB:0] = offset_word_ch_d_reg;
            qmc_pkg::SEL_GAIN_A: rd_mux[`QMC_GAIN_MSB:0] = gain_word_ch_a_reg;
            qmc_pkg::SEL_MIX_GAIN_B: begin
                rd_mux[`QMC_GAIN_MSB:0] = gain_word_ch_b_reg;
                rd_mux[`QMC_CMIX_MSB:`QMC_CMIX_LSB] = cmix_mode_reg;
            end
            qmc_pkg::SEL_SYNC_CTRL: rd_mux[`QMC_SYNC_EN_BIT] = sync_en_reg;
            qmc_pkg::SEL_STATUS: begin
                rd_mux[`QMC_OFFSET_MSB:0] = active_c_reg;
                rd_mux[`QMC_STAT_D_MSB:`QMC_STAT_D_LSB] = active_d_reg;
            end
            qmc_pkg::SEL_NONE: rd_mux = 32'h0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register file next state
    always_comb begin
        offset_word_ch_c_next = offset_word_ch_c_reg;
        offset_word_ch_d_next = offset_word_ch_d_reg;
        gain_word_ch_a_next = gain_word_ch_a_reg;
        gain_word_ch_b_next = gain_word_ch_b_reg;
        cmix_mode_next = cmix_mode_reg;
        sync_en_next = sync_en_reg;
        prdata_next = rd_cap ? rd_mux : prdata_reg;
        if (wr_en) begin
            unique case (sel)
                qmc_pkg::SEL_OFFSET_C:
                    offset_word_ch_c_next = PWDATA[`QMC_OFFSET_MSB:0];
                qmc_pkg::SEL_OFFSET_D:
                    offset_word_ch_d_next = PWDATA[`QMC_OFFSET_MSB:0];
                qmc_pkg::SEL_GAIN_A:
                    gain_word_ch_a_next = PWDATA[`QMC_GAIN_MSB:0];
                qmc_pkg::SEL_MIX_GAIN_B: begin
                    gain_word_ch_b_next = PWDATA[`QMC_GAIN_MSB:0];
                    cmix_mode_next = PWDATA[`QMC_CMIX_MSB:`QMC_CMIX_LSB];
                end
                qmc_pkg::SEL_SYNC_CTRL: sync_en_next = PWDATA[`QMC_SYNC_EN_BIT];
                qmc_pkg::SEL_STATUS: sync_en_next = sync_en_reg;
                qmc_pkg::SEL_NONE: sync_en_next = sync_en_reg;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Active offsets: the pair only moves together on a C write, so the corrected lanes
    // see no new C with a stale D as long as D is written before C; a manual load
    // bit covers the case where auto-sync is switched off
    always_comb begin
        sync_load = 1'b0;
        active_c_next = active_c_reg;
        active_d_next = active_d_reg;
        if (wr_en && sel == qmc_pkg::SEL_OFFSET_C && sync_en_reg) begin
            sync_load = 1'b1;
            active_c_next = PWDATA[`QMC_OFFSET_MSB:0];
            active_d_next = offset_word_ch_d_reg;
        end else if (wr_en && sel == qmc_pkg::SEL_SYNC_CTRL && PWDATA[`QMC_SYNC_LOAD_BIT]) begin
            sync_load = 1'b1;
            active_c_next = offset_word_ch_c_reg;
            active_d_next = offset_word_ch_d_reg;
        end
        // A write to the D offset alone falls through here untouched
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            offset_word_ch_c_reg <= `QMC_RST_OFFSET;
            offset_word_ch_d_reg <= `QMC_RST_OFFSET;
            gain_word_ch_a_reg <= `QMC_RST_GAIN;
            gain_word_ch_b_reg <= `QMC_RST_GAIN;
            cmix_mode_reg <= `QMC_RST_CMIX;
            sync_en_reg <= `QMC_RST_SYNC_EN;
            active_c_reg <= `QMC_RST_OFFSET;
            active_d_reg <= `QMC_RST_OFFSET;
            prdata_reg <= 32'h0;
        end else if (CE) begin
            offset_word_ch_c_reg <= offset_word_ch_c_next;
            offset_word_ch_d_reg <= offset_word_ch_d_next;
            gain_word_ch_a_reg <= gain_word_ch_a_next;
            gain_word_ch_b_reg <= gain_word_ch_b_next;
            cmix_mode_reg <= cmix_mode_next;
            sync_en_reg <= sync_en_next;
            active_c_reg <= active_c_next;
            active_d_reg <= active_d_next;
            prdata_reg <= prdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Correction lanes: A and B carry gain, C and D carry offset; the gains
    // of C and D and the offsets of A and B live elsewhere and sit at
    // neutral values here
    always_comb begin
        lane_in[0] = SAMPLE_A_IN;
        lane_in[1] = SAMPLE_B_IN;
        lane_in[2] = SAMPLE_C_IN;
        lane_in[3] = SAMPLE_D_IN;
        lane_gain[0] = gain_word_ch_a_reg;
        lane_gain[1] = gain_word_ch_b_reg;
        lane_gain[2] = `QMC_RST_GAIN;
        lane_gain[3] = `QMC_RST_GAIN;
        lane_off[0] = $signed(`QMC_RST_OFFSET);
        lane_off[1] = $signed(`QMC_RST_OFFSET);
        lane_off[2] = $signed(active_c_reg);
        lane_off[3] = $signed(active_d_reg);
    end

    for (genvar g = 0; g < 4; g++) begin : g_lane
        gain_offset_lane #(
            .DW(DW),
            .GW(GW),
            .OW(OW),
            .FRAC(`QMC_GAIN_FRAC)
        ) u_lane (
            .clk(SYS_CLK),
            .rst(RST),
            .ce(CE),
            .sample_in(lane_in[g]),
            .gain(lane_gain[g]),
            .offset(lane_off[g]),
            .sample_out(lane_out[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // Coarse mixers, one per I/Q pair, sharing the mode field
    coarse_mixer #(
        .DW(DW)
    ) u_mix_ab (
        .clk(SYS_CLK),
        .rst(RST),
        .ce(CE),
        .mode(cmix_mode_reg),
        .i_in(lane_out[0]),
        .q_in(lane_out[1]),
        .i_out(SAMPLE_A_OUT),
        .q_out(SAMPLE_B_OUT)
    );

    coarse_mixer #(
        .DW(DW)
    ) u_mix_cd (
        .clk(SYS_CLK),
        .rst(RST),
        .ce(CE),
        .mode(cmix_mode_reg),
        .i_in(lane_out[2]),
        .q_in(lane_out[3]),
        .i_out(SAMPLE_C_OUT),
        .q_out(SAMPLE_D_OUT)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (RST);

    sequence wr_c_s;
        wr_en && sel == qmc_pkg::SEL_OFFSET_C;
    endsequence

    sequence wr_d_s;
        wr_en && sel == qmc_pkg::SEL_OFFSET_D;
    endsequence

    sequence auto_sync_s;
        wr_en && sel == qmc_pkg::SEL_OFFSET_C && sync_en_reg;
    endsequence

    offset_c_store_a: assert property (
        wr_c_s |=> offset_word_ch_c_reg == $past(PWDATA[`QMC_OFFSET_MSB:0]))
        else $error("Channel C offset not stored");

    offset_d_store_a: assert property (
        wr_d_s |=> offset_word_ch_d_reg == $past(PWDATA[`QMC_OFFSET_MSB:0]))
        else $error("Channel D offset not stored");

    auto_sync_fire_a: assert property (
        auto_sync_s |=> active_c_reg == offset_word_ch_c_reg)
        else $error("Auto-sync did not load channel C");

    pair_load_a: assert property (
        auto_sync_s |=>
            active_d_reg == $past(offset_word_ch_d_reg)
            && active_c_reg == $past(PWDATA[`QMC_OFFSET_MSB:0]))
        else $error("Offset pair not loaded together");

    d_write_hold_a: assert property (
        wr_d_s ##0 !sync_load |=> $stable(active_d_reg) && $stable(active_c_reg))
        else $error("Channel D write changed active offset");

    gain_a_store_a: assert property (
        wr_en && sel == qmc_pkg::SEL_GAIN_A |=>
            gain_word_ch_a_reg == $past(PWDATA[`QMC_GAIN_MSB:0]))
        else $error("Channel A gain not stored");

    gain_b_mode_a: assert property (
        wr_en && sel == qmc_pkg::SEL_MIX_GAIN_B |=>
            gain_word_ch_b_reg == $past(PWDATA[`QMC_GAIN_MSB:0])
            && cmix_mode_reg == $past(PWDATA[`QMC_CMIX_MSB:`QMC_CMIX_LSB]))
        else $error("Channel B gain or mixer mode not stored");

    unity_gain_a: assert property (
        CE && gain_word_ch_a_reg == `QMC_RST_GAIN |=> lane_out[0] == $past(SAMPLE_A_IN))
        else $error("Unity gain does not pass the sample");

    reset_values_a: assert property (
        $past(RST) |-> gain_word_ch_a_reg == `QMC_RST_GAIN
            && gain_word_ch_b_reg == `QMC_RST_GAIN && cmix_mode_reg == `QMC_RST_CMIX
            && offset_word_ch_c_reg == `QMC_RST_OFFSET
            && offset_word_ch_d_reg == `QMC_RST_OFFSET)
        else $error("Reset values wrong");

    reserved_zero_a: assert property (
        rd_cap && (sel == qmc_pkg::SEL_OFFSET_C || sel == qmc_pkg::SEL_OFFSET_D) |=>
            PRDATA[31:`QMC_OFFSET_MSB+1] == '0)
        else $error("Reserved offset bits read nonzero");

    mixer_bypass_a: assert property (
        CE && cmix_mode_reg == `QMC_RST_CMIX && u_mix_ab.phase_reg == 3'h0
            |=> SAMPLE_A_OUT == $past(lane_out[0]) && SAMPLE_B_OUT == $past(lane_out[1]))
        else $error("Mixer altered samples with no mode set");

endmodule : qmc_cmix_top
`default_nettype wire

// file: verif/qmc_cmix_top_bench.sv
// Self-checking bench for the offset, gain and coarse mixer register block
`timescale 1ns/1ps
`default_nettype none
module qmc_cmix_top_bench;
    logic SYS_CLK = 1'b0;
    logic RST = 1'b1;
    // Clock enable is dropped once to show that the lanes hold their outputs
    logic CE = 1'b1;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h00000000;
    logic [31:0] PRDATA;
    logic PREADY;
    logic PSLVERR;
    logic signed [15:0] SAMPLE_A_IN = 16'h0000;
    logic signed [15:0] SAMPLE_B_IN = 16'h0000;
    logic signed [15:0] SAMPLE_C_IN = 16'h0000;
    logic signed [15:0] SAMPLE_D_IN = 16'h0000;
    logic signed [15:0] SAMPLE_A_OUT;
    logic signed [15:0] SAMPLE_B_OUT;
    logic signed [15:0] SAMPLE_C_OUT;
    logic signed [15:0] SAMPLE_D_OUT;
    int miscompares = 0;
    int tests_run = 0;
    logic [31:0] rdata;
    logic err;
    logic signed [15:0] v [24];
    logic signed [15:0] w [24];
    int mag;
    logic [3:0] modes [7] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'h6, 4'hC, 4'hF};
    int ks [7] = '{4, 2, 1, 2, 2, 4, 4};
    logic signed [16:0] s;

    qmc_cmix_top dut (.SYS_CLK(SYS_CLK), .RST(RST), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .SAMPLE_A_IN(SAMPLE_A_IN), .SAMPLE_B_IN(SAMPLE_B_IN),
        .SAMPLE_C_IN(SAMPLE_C_IN), .SAMPLE_D_IN(SAMPLE_D_IN), .SAMPLE_A_OUT(SAMPLE_A_OUT),
        .SAMPLE_B_OUT(SAMPLE_B_OUT), .SAMPLE_C_OUT(SAMPLE_C_OUT), .SAMPLE_D_OUT(SAMPLE_D_OUT));

    always #5 SYS_CLK = ~SYS_CLK;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Request held until the edge where pready is seen high; data taken there
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge SYS_CLK);
        PSEL <= 1'b1;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= wd;
        @(posedge SYS_CLK);
        PENABLE <= 1'b1;
        do begin
            @(posedge SYS_CLK);
        end while (PREADY !== 1'b1);
        rdata = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
        chk("write error", 32'h00000000, {31'h0, err});
    endtask : wr

    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h00000000);
        chk(nm, e, rdata);
        chk("read error", 32'h00000000, {31'h0, err});
    endtask : rd

    // Two-stage sample pipeline; a few extra edges for margin
    task automatic settle;
        repeat (4) @(posedge SYS_CLK);
        #1;
    endtask : settle

    task automatic outs(input logic [15:0] c, input logic [15:0] d);
        chk("lane c", {16'h0000, c}, {16'h0000, SAMPLE_C_OUT});
        chk("lane d", {16'h0000, d}, {16'h0000, SAMPLE_D_OUT});
    endtask : outs

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #300000;
        miscompares++;
        end_sim();
    end

    initial begin
        repeat (5) @(posedge SYS_CLK);
        RST <= 1'b0;
        rd("offset c", 8'h28, 32'h00000000);
        rd("offset d", 8'h2C, 32'h00000000);
        rd("gain a", 8'h30, 32'h00000400);
        rd("mix gain b", 8'h34, 32'h00000400);
        rd("active", 8'h7C, 32'h00000000);
        wr(8'h30, 32'hFFFFFFFF);
        rd("gain a", 8'h30, 32'h000007FF);
        wr(8'h34, 32'h00000E00);
        rd("mix gain b", 8'h34, 32'h00000600);
        wr(8'h2C, 32'h0000FFFF);
        rd("offset d", 8'h2C, 32'h00001FFF);
        rd("active", 8'h7C, 32'h00000000);
        wr(8'h28, 32'h0000F001);
        rd("offset c", 8'h28, 32'h00001001);
        rd("active", 8'h7C, 32'h1FFF1001);
        SAMPLE_A_IN <= 16'h03E8;
        SAMPLE_B_IN <= 16'hFC18;
        SAMPLE_C_IN <= 16'h7D00;
        SAMPLE_D_IN <= 16'h8AD0;
        settle();
        chk("lane a", {16'h0000, 16'h07CF}, {16'h0000, SAMPLE_A_OUT});
        chk("lane b", {16'h0000, 16'hFA24}, {16'h0000, SAMPLE_B_OUT});
        outs(16'h6D01, 16'h8ACF);
        // Host order: far offset first, then the one that triggers the load
        wr(8'h2C, 32'h00001000);
        settle();
        outs(16'h6D01, 16'h8ACF);
        wr(8'h28, 32'h00000FFF);
        settle();
        outs(16'h7FFF, 16'h8000);
        @(posedge SYS_CLK);
        CE <= 1'b0;
        SAMPLE_C_IN <= 16'h0000;
        settle();
        outs(16'h7FFF, 16'h8000);
        @(posedge SYS_CLK);
        CE <= 1'b1;
        SAMPLE_C_IN <= 16'h7D00;
        rd("active", 8'h7C, 32'h10000FFF);
        wr(8'h78, 32'h00000000);
        wr(8'h28, 32'h00000000);
        rd("active", 8'h7C, 32'h10000FFF);
        wr(8'h78, 32'h00000003);
        rd("active", 8'h7C, 32'h10000000);
        xfer(1'b1, 8'h40, 32'h12345678);
        chk("unmapped write error", 32'h00000001, {31'h0, err});
        xfer(1'b0, 8'h40, 32'h00000000);
        chk("unmapped read error", 32'h00000001, {31'h0, err});
        chk("unmapped data", 32'h00000000, rdata);
        xfer(1'b0, 8'h29, 32'h00000000);
        chk("misaligned read error", 32'h00000001, {31'h0, err});
        wr(8'h30, 32'h00000400);
        // A half-turn after k samples negates lane A; a full turn after 2k restores it
        for (int m = 0; m < 7; m++) begin
            wr(8'h34, {16'h0000, modes[m], 12'h400});
            rd("mix mode", 8'h34, {16'h0000, modes[m], 12'h400});
            repeat (3) @(posedge SYS_CLK);
            for (int i = 0; i < 24; i++) begin
                @(posedge SYS_CLK);
                #1;
                v[i] = SAMPLE_A_OUT;
                w[i] = SAMPLE_B_OUT;
            end
            for (int n = 0; n < 8; n++) begin
                tests_run++;
                s = 17'(v[n]) + 17'(v[n + ks[m]]);
                if ((s >= -17'sd1 && s <= 17'sd1) !== 1'b1) begin
                    miscompares++;
                    $display("mismatch mixer half turn expected %h seen %h", -v[n], v[n + ks[m]]);
                end
                chk("mixer full turn", {16'h0000, v[n]}, {16'h0000, v[n + 2 * ks[m]]});
                // Rotation keeps the pair's magnitude, so a dead or zeroed mixer shows here
                mag = int'(v[n]) * int'(v[n]) + int'(w[n]) * int'(w[n]);
                tests_run++;
                if (mag < 1990000 || mag > 2010000) begin
                    miscompares++;
                    $display("mismatch mixer magnitude expected %0d seen %0d", 2000000, mag);
                end
            end
        end
        end_sim();
    end
endmodule : qmc_cmix_top_bench
`default_nettype wire
